/* rtl/sfi_status_flag_unit.sv */
// status flags, power-good levels, interrupt mask and interrupt pin
`timescale 1ns/1ps
// Behaviour
// - sleep timer wake sets flag bit 7
// - flags sticky until status register read
// - low supply deglitched sets bit 6, suppressed
// - core regulator not good filtered sets bit 5
// - over shutdown temperature sets bit 4
// - over warning temperature sets bit 3
// - booster on, idle too long sets bit 2
// - booster not good filtered sets bit 1
// - bit 0 reports interconnect high, direction 0
// - live core good bit when not off
// - live booster good bit when on
// - mask bits 7..1 block their flags
// - booster interrupt from good low while on
// - mask bit 0 enables interrupt pin
// - info bits 7..6 give sense amp bin
// - status, levels, mask reset to zero
// - reserved bits read zero, writes ignored
// - target address from address select pin
// - status read releases cleared fault states
module sfi_status_flag_unit #(
    parameter int SUPPLY_SUPPRESS_CYC = sfi_pkg::us_to_cyc(sfi_pkg::SUPPLY_SUPPRESS_US),
    parameter int SUPPLY_DEGLITCH_CYC = sfi_pkg::us_to_cyc(sfi_pkg::SUPPLY_DEGLITCH_US),
    parameter int CORE_FILTER_CYC     = sfi_pkg::us_to_cyc(sfi_pkg::CORE_FILTER_US),
    parameter int CORE_MASK_CYC       = sfi_pkg::us_to_cyc(sfi_pkg::CORE_MASK_US),
    parameter int BOOST_FILTER_CYC    = sfi_pkg::us_to_cyc(sfi_pkg::BOOST_FILTER_US),
    parameter int BOOST_MASK_CYC      = sfi_pkg::us_to_cyc(sfi_pkg::BOOST_MASK_US),
    parameter int BOOST_ACT0_CYC      = sfi_pkg::us_to_cyc(sfi_pkg::BOOST_ACT0_US),
    parameter int BOOST_ACT1_CYC      = sfi_pkg::us_to_cyc(sfi_pkg::BOOST_ACT1_US),
    parameter int BOOST_ACT2_CYC      = sfi_pkg::us_to_cyc(sfi_pkg::BOOST_ACT2_US),
    parameter int BOOST_ACT3_CYC      = sfi_pkg::us_to_cyc(sfi_pkg::BOOST_ACT3_US)
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rstn,
    // register access
    input  wire sfi_pkg::sfi_req_t i_req,
    output logic [7:0]            o_reg_rdata,
    // settings and internal events
    input  wire sfi_pkg::sfi_cfg_t i_cfg,
    input  wire logic             i_sleep_wake,
    input  wire logic             i_temp_below_release,
    // analog monitor pins
    input  wire logic             i_supply_below_low,
    input  wire logic             i_core_regulator_above,
    input  wire logic             i_temp_over_shutdown,
    input  wire logic             i_temp_over_warning,
    input  wire logic             i_booster_switch,
    input  wire logic             i_booster_above,
    input  wire logic             i_interconnect_high,
    input  wire logic             i_addr_select_pin,
    input  wire logic [1:0]       i_sense_amp_bin,
    // outputs
    output logic                  o_int_mcu,
    output logic [6:0]            o_target_addr,
    output logic                  o_core_fault_release,
    output logic                  o_thermal_fault_release
);
    localparam int NP = sfi_pkg::NUM_PINS;
    localparam int P_SUP = 0;
    localparam int P_CORE = 1;
    localparam int P_TSH = 2;
    localparam int P_TWR = 3;
    localparam int P_BSW = 4;
    localparam int P_BGD = 5;
    localparam int P_ICN = 6;
    localparam int P_ASEL = 7;
    localparam int P_BIN = 8;

    generate
        if (SUPPLY_SUPPRESS_CYC < 1 || SUPPLY_DEGLITCH_CYC < 1 || CORE_FILTER_CYC < 1 || CORE_MASK_CYC < 1 ||
            BOOST_FILTER_CYC < 1 || BOOST_MASK_CYC < 1 || BOOST_ACT0_CYC < 1 || BOOST_ACT1_CYC < 1 ||
            BOOST_ACT2_CYC < 1 || BOOST_ACT3_CYC < 1) begin : g_bad_param
            $error("sfi_status_flag_unit: every cycle count must be at least one");
        end
    endgenerate

    typedef struct packed {
        logic [NP-1:0] s1;
        logic [NP-1:0] s2;
        logic [NP-1:0] s3;
        logic [NP-1:0] pin;
        logic [7:0]    flags;
        logic [7:0]    mask;
        logic [7:0]    rdata;
        logic [1:0]    bin;
        logic [1:0]    settle;
        logic [6:0]    taddr;
        logic          irq;
        logic          core_rel;
        logic          therm_rel;
        logic          sup_set_q;
        logic          core_off_q;
        logic [1:0]    core_vsel_q;
        logic          bst_on_q;
        logic [7:0]    bst_vsel_q;
        logic [31:0]   sup_supp;
        logic [31:0]   sup_deg;
        logic [31:0]   core_flt;
        logic [31:0]   core_msk;
        logic [31:0]   bst_flt;
        logic [31:0]   bst_msk;
        logic [31:0]   bst_act;
    } sfi_state_t;

    sfi_state_t state_reg;
    sfi_state_t state_next;

    // saturating up-counter while cond holds, cleared otherwise
    function automatic logic [31:0] run_cnt(input logic cond, input logic [31:0] cnt, input logic [31:0] lim);
        if (!cond) begin
            return 32'h0000_0000;
        end
        return (cnt >= lim) ? lim : cnt + 32'h0000_0001;
    endfunction

    // count reaches its limit this cycle
    function automatic logic hit(input logic cond, input logic [31:0] cnt, input logic [31:0] lim);
        return cond && (cnt == lim - 32'h0000_0001);
    endfunction

    // down-counter reloaded on a trigger, blocks detection while nonzero
    function automatic logic [31:0] hold_cnt(input logic load, input logic [31:0] cnt, input logic [31:0] lim);
        if (load) begin
            return lim;
        end
        return (cnt == 32'h0000_0000) ? cnt : cnt - 32'h0000_0001;
    endfunction

    logic [NP-1:0] pins_raw;
    assign pins_raw = {i_sense_amp_bin, i_addr_select_pin, i_interconnect_high, i_booster_above, i_booster_switch,
                       i_temp_over_warning, i_temp_over_shutdown, i_core_regulator_above, i_supply_below_low};

    always_comb begin
        logic [7:0]  set_v;
        logic [7:0]  clr_v;
        logic [31:0] act_lim;
        logic        st_rd;
        logic        core_good;
        logic        bst_good;
        logic        bst_good_q;
        logic        idle_cond;
        logic        sup_cond;
        logic        core_cond;
        logic        bst_cond;
        set_v      = 8'h00;
        clr_v      = 8'h00;
        state_next = state_reg;

        state_next.s1 = pins_raw;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < NP; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.pin[i] = state_reg.s3[i];
            end
        end

        // strap followed only once the synchroniser has settled after reset
        if (state_reg.settle != 2'(sfi_pkg::STRAP_SETTLE_CYC)) begin
            state_next.settle = state_reg.settle + 2'h1;
        end else begin
            state_next.bin    = state_reg.pin[P_BIN+1:P_BIN];
        end
        state_next.taddr = state_reg.pin[P_ASEL] ? sfi_pkg::ADDR_SEL_HIGH : sfi_pkg::ADDR_SEL_LOW;

        core_good  = state_reg.pin[P_CORE] && !i_cfg.core_regulator_off;
        bst_good   = state_reg.pin[P_BGD] && i_cfg.booster_on;
        bst_good_q = state_reg.s3[P_BGD] && state_reg.pin[P_BGD];

        // supply low: suppression window starts when the setting drops to 0
        state_next.sup_set_q = i_cfg.supply_low_monitor_setting;
        state_next.sup_supp  = hold_cnt(state_reg.sup_set_q && !i_cfg.supply_low_monitor_setting,
                                        state_reg.sup_supp, 32'(SUPPLY_SUPPRESS_CYC));
        sup_cond = state_reg.pin[P_SUP] && i_cfg.supply_low_monitor_setting && state_reg.sup_supp == 32'h0;
        state_next.sup_deg = run_cnt(sup_cond, state_reg.sup_deg, 32'(SUPPLY_DEGLITCH_CYC));
        set_v[sfi_pkg::BIT_SUPPLY_LOW] = hit(sup_cond, state_reg.sup_deg, 32'(SUPPLY_DEGLITCH_CYC));

        // core regulator fault, masked after voltage or disable change
        state_next.core_off_q  = i_cfg.core_regulator_off;
        state_next.core_vsel_q = i_cfg.core_regulator_voltage_sel;
        state_next.core_msk = hold_cnt(state_reg.core_off_q != i_cfg.core_regulator_off ||
                                       state_reg.core_vsel_q != i_cfg.core_regulator_voltage_sel,
                                       state_reg.core_msk, 32'(CORE_MASK_CYC));
        core_cond = !i_cfg.core_regulator_off && !state_reg.pin[P_CORE] && state_reg.core_msk == 32'h0;
        state_next.core_flt = run_cnt(core_cond, state_reg.core_flt, 32'(CORE_FILTER_CYC));
        set_v[sfi_pkg::BIT_CORE_FAULT] = hit(core_cond, state_reg.core_flt, 32'(CORE_FILTER_CYC));

        set_v[sfi_pkg::BIT_THERMAL_SHUT] = state_reg.pin[P_TSH];
        set_v[sfi_pkg::BIT_THERMAL_WARN] = state_reg.pin[P_TWR];
        set_v[sfi_pkg::BIT_SLEEP_WAKE]   = i_sleep_wake;

        // booster inactivity: any edge on the switch node restarts the count
        case (i_cfg.booster_act_time_sel)
            2'h0:    act_lim = 32'(BOOST_ACT0_CYC);
            2'h1:    act_lim = 32'(BOOST_ACT1_CYC);
            2'h2:    act_lim = 32'(BOOST_ACT2_CYC);
            2'h3:    act_lim = 32'(BOOST_ACT3_CYC);
            default: act_lim = 32'(BOOST_ACT0_CYC);
        endcase
        idle_cond = i_cfg.booster_on && !i_cfg.sleep_request &&
                    (state_reg.s3[P_BSW] == state_reg.pin[P_BSW]);
        state_next.bst_act = run_cnt(idle_cond, state_reg.bst_act, act_lim);
        set_v[sfi_pkg::BIT_BOOSTER_IDLE] = hit(idle_cond, state_reg.bst_act, act_lim);

        // booster fault, masked after voltage or enable change
        state_next.bst_on_q   = i_cfg.booster_on;
        state_next.bst_vsel_q = i_cfg.booster_voltage_sel;
        state_next.bst_msk = hold_cnt(state_reg.bst_on_q != i_cfg.booster_on ||
                                      state_reg.bst_vsel_q != i_cfg.booster_voltage_sel,
                                      state_reg.bst_msk, 32'(BOOST_MASK_CYC));
        // filter runs whenever good is low in s3 or pin while on and bst_msk is zero, so the interrupt needs no fall
        bst_cond = i_cfg.booster_on && !bst_good_q && state_reg.bst_msk == 32'h0;
        state_next.bst_flt = run_cnt(bst_cond, state_reg.bst_flt, 32'(BOOST_FILTER_CYC));
        set_v[sfi_pkg::BIT_BOOSTER_FAULT] = hit(bst_cond, state_reg.bst_flt, 32'(BOOST_FILTER_CYC));

        set_v[sfi_pkg::BIT_INTERCONNECT] = state_reg.pin[P_ICN] && !i_cfg.interconnect_dir;

        // register access; read data registered, status clear on read
        st_rd = i_req.rd && i_req.addr == sfi_pkg::OFS_EVENT_FLAGS;
        if (i_req.rd) begin
            case (i_req.addr)
                sfi_pkg::OFS_DEVICE_INFORMATION: state_next.rdata = {state_reg.bin, 6'h00};
                sfi_pkg::OFS_EVENT_FLAGS:        state_next.rdata = state_reg.flags;
                sfi_pkg::OFS_POWER_GOOD_LEVELS:  state_next.rdata = {6'h00, core_good, bst_good};
                sfi_pkg::OFS_INTERRUPT_SUPPRESS: state_next.rdata = state_reg.mask;
                default:                         state_next.rdata = sfi_pkg::RD_UNMAPPED;
            endcase
        end
        // only bits actually returned are cleared, and a new set wins
        if (st_rd) begin
            clr_v = state_reg.flags;
        end
        state_next.flags = (state_reg.flags & ~clr_v) | set_v;
        if (i_req.wr && i_req.addr == sfi_pkg::OFS_INTERRUPT_SUPPRESS) begin
            state_next.mask = i_req.wdata;
        end

        state_next.core_rel  = st_rd && state_reg.pin[P_CORE] && !i_cfg.core_regulator_off;
        state_next.therm_rel = st_rd && i_temp_below_release;

        // flag 0 has no block bit of its own
        state_next.irq = state_next.mask[sfi_pkg::BIT_STATUS_INT_EN] &&
                         |(state_next.flags & {~state_next.mask[7:1], 1'b1});
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg       <= '0;
            state_reg.flags <= sfi_pkg::RST_EVENT_FLAGS;
            state_reg.mask  <= sfi_pkg::RST_INTERRUPT_SUPPRESS;
            state_reg.taddr <= sfi_pkg::ADDR_SEL_LOW;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_reg_rdata             = state_reg.rdata;
    assign o_int_mcu               = state_reg.irq;
    assign o_target_addr           = state_reg.taddr;
    assign o_core_fault_release    = state_reg.core_rel;
    assign o_thermal_fault_release = state_reg.therm_rel;
endmodule // sfi_status_flag_unit

/* rtl/sfi_pkg.sv */
// shared constants and carrier types of the status flag interrupt unit
package sfi_pkg;
    // register offsets
    localparam logic [7:0] OFS_DEVICE_INFORMATION = 8'h00;
    localparam logic [7:0] OFS_EVENT_FLAGS        = 8'h01;
    localparam logic [7:0] OFS_POWER_GOOD_LEVELS  = 8'h02;
    localparam logic [7:0] OFS_INTERRUPT_SUPPRESS = 8'h03;
    // reset values
    localparam logic [7:0] RST_EVENT_FLAGS        = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_SUPPRESS = 8'h00;
    localparam logic [7:0] RD_UNMAPPED            = 8'h00;
    // event flag bit positions (mask register uses the same positions for bits 7..1)
    localparam int BIT_SLEEP_WAKE      = 7;
    localparam int BIT_SUPPLY_LOW      = 6;
    localparam int BIT_CORE_FAULT      = 5;
    localparam int BIT_THERMAL_SHUT    = 4;
    localparam int BIT_THERMAL_WARN    = 3;
    localparam int BIT_BOOSTER_IDLE    = 2;
    localparam int BIT_BOOSTER_FAULT   = 1;
    localparam int BIT_INTERCONNECT    = 0;
    localparam int BIT_STATUS_INT_EN   = 0;
    localparam int BIT_CORE_GOOD       = 1;
    localparam int BIT_BOOSTER_GOOD    = 0;
    localparam int BIN_LSB             = 6;
    // target addresses chosen by the address select pin
    localparam logic [6:0] ADDR_SEL_LOW  = 7'h3F;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h2A;
    // timing
    localparam int CLK_PERIOD_PS        = 5000;
    localparam int SUPPLY_SUPPRESS_US   = 1000;
    localparam int SUPPLY_DEGLITCH_US   = 100;
    localparam int CORE_FILTER_US       = 125;
    localparam int CORE_MASK_US         = 10000;
    localparam int BOOST_FILTER_US      = 125;
    localparam int BOOST_MASK_US        = 10000;
    localparam int BOOST_ACT0_US        = 100;
    localparam int BOOST_ACT1_US        = 1000;
    localparam int BOOST_ACT2_US        = 10000;
    localparam int BOOST_ACT3_US        = 100000;
    localparam int STRAP_SETTLE_CYC     = 3;
    localparam int NUM_PINS             = 10;

    // cycles for a time in microseconds, rounded up, at least one
    function automatic int us_to_cyc(input int us);
        longint ps;
        ps = longint'(us) * 64'd1000000;
        return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1 ? 1 : int'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    endfunction

    // register access from the serial target logic
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfi_req_t;

    // settings held in configuration and enable registers
    typedef struct packed {
        logic       supply_low_monitor_setting;
        logic       core_regulator_off;
        logic [1:0] core_regulator_voltage_sel;
        logic       booster_on;
        logic [7:0] booster_voltage_sel;
        logic       sleep_request;
        logic       interconnect_dir;
        logic [1:0] booster_act_time_sel;
    } sfi_cfg_t;
endpackage : sfi_pkg

/* sim/sfi_host_model.sv */
// register host model standing in for the external controller
`timescale 1ns/1ps
module sfi_host_model (
    // clock
    input  wire logic         i_mclk,
    // register access toward the unit
    output sfi_pkg::sfi_req_t o_req
);
    initial o_req = '0;
    // one byte access per call; caller stands just past a rising edge
    task automatic access(input logic rd, input logic wr, input logic [7:0] addr, input logic [7:0] data);
        o_req <= '{rd: rd, wr: wr, addr: addr, wdata: data};
        @(posedge i_mclk);
    endtask
    // released bus shows inverted leftovers, never the last value
    task automatic idle(input int n);
        o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~o_req.addr, wdata: ~o_req.wdata};
        repeat (n) @(posedge i_mclk);
    endtask
endmodule // sfi_host_model

/* sim/sfi_status_flag_unit_props.sv */
// port assertions of the status flag interrupt unit
`timescale 1ns/1ps
module sfi_status_flag_unit_props (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    // watched ports
    input  wire sfi_pkg::sfi_req_t i_req,
    input  wire sfi_pkg::sfi_cfg_t i_cfg,
    input  wire logic              i_sleep_wake,
    input  wire logic              i_addr_select_pin,
    input  wire logic [7:0]        o_reg_rdata,
    input  wire logic              o_int_mcu,
    input  wire logic [6:0]        o_target_addr
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    wire rd_st = i_req.rd && i_req.addr == 8'h01 && !i_sleep_wake;
    wire rd_pg = i_req.rd && i_req.addr == 8'h02;
    chk_rdata_hold: assert property (!$past(i_req.rd) |-> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    chk_wake_flag: assert property (i_sleep_wake ##1 rd_st |=> o_reg_rdata[7])
        else $error("wake flag missing from status read");
    chk_flag_clear: assert property (rd_st ##1 rd_st |=> !o_reg_rdata[7])
        else $error("wake flag survived a status read");
    chk_int_disable: assert property (i_req.wr && i_req.addr == 8'h03 && !i_req.wdata[0] |=> !o_int_mcu)
        else $error("interrupt high with output disabled");
    chk_mask_back: assert property ((i_req.wr && i_req.addr == 8'h03) ##1 (i_req.rd && i_req.addr == 8'h03)
        |=> o_reg_rdata == $past(i_req.wdata, 2)) else $error("mask read back differs");
    chk_level_rsvd: assert property (rd_pg |=> o_reg_rdata[7:2] == 6'h00)
        else $error("reserved level bits not zero");
    chk_info_rsvd: assert property (i_req.rd && i_req.addr == 8'h00 |=> o_reg_rdata[5:0] == 6'h00)
        else $error("reserved information bits not zero");
    chk_unmapped_zero: assert property (i_req.rd && i_req.addr > 8'h03 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_core_off: assert property (i_cfg.core_regulator_off ##1 (i_cfg.core_regulator_off && rd_pg)
        |=> !o_reg_rdata[1]) else $error("core good shown while off");
    chk_boost_off: assert property (!i_cfg.booster_on ##1 (!i_cfg.booster_on && rd_pg)
        |=> !o_reg_rdata[0]) else $error("booster good shown while off");
    chk_addr_high: assert property (i_addr_select_pin [*8] |-> o_target_addr == 7'h2A)
        else $error("target address wrong for high select");
    chk_addr_low: assert property (!i_addr_select_pin [*8] |-> o_target_addr == 7'h3F)
        else $error("target address wrong for low select");
    cover property (rd_st ##1 o_reg_rdata[7]);
    cover property ($rose(o_int_mcu));
    cover property (o_target_addr == 7'h2A);
endmodule // sfi_status_flag_unit_props

bind sfi_status_flag_unit sfi_status_flag_unit_props u_props (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req),
    .i_cfg(i_cfg), .i_sleep_wake(i_sleep_wake), .i_addr_select_pin(i_addr_select_pin),
    .o_reg_rdata(o_reg_rdata), .o_int_mcu(o_int_mcu), .o_target_addr(o_target_addr));

/* sim/testbench.sv */
// self-checking bench of the status flag interrupt unit
`timescale 1ns/1ps
module testbench;
    logic              i_mclk, i_rstn, wake, sup_low, core_up, t_shut, t_warn, sw, sw_en, bst_up, icon, sel;
    logic              int_mcu, rd_d, t_rel, core_rel, therm_rel;
    sfi_pkg::sfi_req_t req;
    sfi_pkg::sfi_cfg_t cfg;
    logic [1:0]        bin;
    logic [6:0]        taddr;
    logic [7:0]        rdata, m;
    logic [7:0]        exp_q[$];
    logic [7:0]        lvl[3] = '{8'h10, 8'h08, 8'h01};
    int                fails = 0, samples_checked = 0, cycles = 0;
    integer            seed = 32'hE4102C89;

    // short counts keep the run brief
    sfi_status_flag_unit #(.SUPPLY_SUPPRESS_CYC(16), .SUPPLY_DEGLITCH_CYC(8), .CORE_FILTER_CYC(8),
        .CORE_MASK_CYC(16), .BOOST_FILTER_CYC(8), .BOOST_MASK_CYC(16), .BOOST_ACT0_CYC(8),
        .BOOST_ACT1_CYC(10), .BOOST_ACT2_CYC(12), .BOOST_ACT3_CYC(14)) dut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req), .o_reg_rdata(rdata), .i_cfg(cfg), .i_sleep_wake(wake),
        .i_temp_below_release(t_rel), .i_supply_below_low(sup_low), .i_core_regulator_above(core_up),
        .i_temp_over_shutdown(t_shut), .i_temp_over_warning(t_warn), .i_booster_switch(sw),
        .i_booster_above(bst_up), .i_interconnect_high(icon), .i_addr_select_pin(sel), .i_sense_amp_bin(bin),
        .o_int_mcu(int_mcu), .o_target_addr(taddr), .o_core_fault_release(core_rel),
        .o_thermal_fault_release(therm_rel));
    sfi_host_model host (.i_mclk(i_mclk), .o_req(req));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) if (sw_en) sw <= ~sw;
    // read data lands one cycle after the read; checked mid-cycle
    always @(posedge i_mclk) rd_d <= req.rd;
    always @(negedge i_mclk) if (rd_d === 1'b1) cmp_rd();
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails = fails + 1;
            $display("mismatch at %0t: run timed out", $time);
            end_sim();
        end
    end

    task automatic cmp_rd();
        logic [7:0] e;
        e = exp_q.pop_front();
        samples_checked++;
        if (rdata !== e) begin
            fails++;
            $display("mismatch at %0t: read %h expected %h", $time, rdata, e);
        end
    endtask
    // settled outputs are looked at on the falling edge
    task automatic cmp_out(input int k, input logic [7:0] e);
        logic [7:0] got;
        @(negedge i_mclk);
        got = (k == 0) ? {7'h00, int_mcu} : (k == 1) ? {1'b0, taddr} : {6'h00, core_rel, therm_rel};
        samples_checked++;
        if (got !== e) begin
            fails++;
            $display("mismatch at %0t: output %h expected %h", $time, got, e);
        end
        @(posedge i_mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b1, 1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b0, 1'b1, a, d);
    endtask
    task automatic end_sim();
        $display("counts: %0d checked, %0d mismatched", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        i_rstn = 1'b0;
        {wake, sup_low, core_up, t_shut, t_warn, sw, sw_en, bst_up, icon, sel, t_rel} = '0;
        cfg = '0;
        cfg.core_regulator_off = 1'b1;
        // settings changes before the masks expire, so later checks are unaffected
        cfg.core_regulator_voltage_sel = 2'($random(seed));
        cfg.booster_voltage_sel = 8'($random(seed));
        cfg.booster_act_time_sel = 2'($random(seed));
        bin = 2'($random(seed));
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
        host.idle(10);
        rd(8'h00, {bin, 6'h00});
        for (int a = 1; a < 4; a++) rd(8'(a), 8'h00);
        rd(8'h07, 8'h00);
        m = 8'($random(seed));
        wr(8'h03, m);
        rd(8'h03, m);
        wr(8'h02, 8'hFF);
        rd(8'h02, 8'h00);
        $display("test registers done");
        wr(8'h03, 8'h81);
        wake <= 1'b1;
        host.idle(1);
        wake <= 1'b0;
        rd(8'h01, 8'h80);
        rd(8'h01, 8'h00);
        wake <= 1'b1;
        host.idle(1);
        wake <= 1'b0;
        host.idle(1);
        cmp_out(0, 8'h00);
        wr(8'h03, 8'h01);
        host.idle(1);
        cmp_out(0, 8'h01);
        rd(8'h01, 8'h80);
        host.idle(2);
        cmp_out(0, 8'h00);
        $display("test interrupt done");
        for (int i = 0; i < 3; i++) begin
            {t_shut, t_warn, icon} <= 3'b100 >> i;
            host.idle(8);
            rd(8'h01, lvl[i]);
            {t_shut, t_warn, icon} <= 3'b000;
            rd(8'h01, lvl[i]);
            host.idle(8);
            rd(8'h01, lvl[i]);
            rd(8'h01, 8'h00);
        end
        cfg.interconnect_dir <= 1'b1;
        icon <= 1'b1;
        host.idle(8);
        rd(8'h01, 8'h00);
        $display("test level flags done");
        {cfg.core_regulator_off, core_up, cfg.booster_on, bst_up, sw_en} <= 5'b01111;
        host.idle(40);
        rd(8'h02, 8'h03);
        rd(8'h01, 8'h00);
        bst_up <= 1'b0;
        host.idle(30);
        bst_up <= 1'b1;
        host.idle(10);
        rd(8'h01, 8'h02);
        rd(8'h01, 8'h00);
        sw_en <= 1'b0;
        host.idle(30);
        cfg.sleep_request <= 1'b1;
        host.idle(4);
        rd(8'h01, 8'h04);
        host.idle(30);
        rd(8'h01, 8'h00);
        {cfg.sleep_request, sw_en, cfg.supply_low_monitor_setting, sup_low} <= 4'b0111;
        host.idle(30);
        sup_low <= 1'b0;
        host.idle(10);
        rd(8'h01, 8'h40);
        core_up <= 1'b0;
        host.idle(30);
        rd(8'h02, 8'h01);
        core_up <= 1'b1;
        t_rel <= 1'b1;
        host.idle(10);
        rd(8'h01, 8'h20);
        host.idle(0);
        cmp_out(2, 8'h03);
        sel <= 1'b1;
        host.idle(10);
        cmp_out(1, 8'h2A);
        $display("test monitors done");
        end_sim();
    end
endmodule // testbench
